// ---- src/sqfd_pkg.sv ----
/*
 * Constants for the squib firing-measure, fire-enable and diagnostic block.
 * Assumes the core clock runs at 25 MHz; all cycle counts derive from it.
 */
package sqfd_pkg;
	localparam int CLK_KHZ = 25000; // Core clock rate in kHz
	localparam int NUM_CH = 8; // Squib channels
	localparam int NUM_FEN = 4; // Fire-enable pins
	localparam int CNT_W = 7; // Measurement counter width
	localparam logic [6:0] CNT_FULL = 7'h7F; // Saturation value
	localparam logic [6:0] CNT_ZERO = 7'h00; // Reset value

	// Count step and status refresh period
	localparam int STEP_NS = 25000;
	localparam int STEP_CYC = STEP_NS * CLK_KHZ / 1000000;
	// Offset compensation period
	localparam int COMP_NS = 12800;
	localparam int COMP_CYC = COMP_NS * CLK_KHZ / 1000000;
	// Enable pin filter, chosen inside the 12 to 16 us window
	localparam int FILT_NS = 14000;
	localparam int FILT_CYC = FILT_NS * CLK_KHZ / 1000000;
	// One millisecond of core cycles, default of a top parameter
	localparam int MS_NS = 1000000;
	localparam int MS_CYC = MS_NS / 1000 * CLK_KHZ / 1000;
	// Comparator settling before leakage results are trusted
	localparam int SETTLE_US = 1000;
	localparam int SETTLE_CYC = SETTLE_US * CLK_KHZ / 1000;

	// Hold delay codes and their lengths in ms
	localparam logic [1:0] HOLD_0 = 2'h0;
	localparam logic [1:0] HOLD_128 = 2'h1;
	localparam logic [1:0] HOLD_256 = 2'h2;
	localparam logic [1:0] HOLD_512 = 2'h3;
	localparam logic [9:0] HOLD_MS_128 = 10'h080;
	localparam logic [9:0] HOLD_MS_256 = 10'h100;
	localparam logic [9:0] HOLD_MS_512 = 10'h200;

	// Response word layout: status bits low, diag flags above
	localparam int RSP_W = 16;
	localparam int RSP_STB = 8; // Battery-short flag position
	localparam int RSP_STG = 9; // Ground-short flag position
	localparam int RSP_VALID = 10; // Diagnostic settled position
endpackage

// ---- src/sqfd_top.sv ----
/*
 * Firing current measurement, real-time current status, fire-enable
 * filters with hold timers, leakage and resistance diagnostic selects,
 * and a serial response shifter on the link clock.
 * Assumes the arm/fire decoder supplies per-channel firing levels and
 * new-sequence pulses, and that host commands arrive as core-clock pulses.
 */
// How it works
// - Eight 7-bit counters time current above threshold
// - One count step is 25 us
// - Counting starts after current passes 95%
// - Counter accumulates until cleared or all ones
// - Saturated counter zeroes on new firing sequence
// - Clear ignored while firing, else re-arms counting
// - Any reset zeroes all eight counters
// - Status request returns per-channel threshold bits
// - Status refreshed every 25 us, captured on select
// - Offset compensation pulse every 12.8 us
// - Enable is filtered pin OR hold latch
// - Pin counts active after 12 to 16 us high
// - Hold latch keeps enable after pin falls
// - Four timers, each governing two channels
// - Timer reloads when pin rises
// - Leakage test: all pulldowns off, bias on pin
// - Loop test: pulldown off only under test
// - Leak flags latched on next select fall
// - Analogue output driven only during resistance measure
// - Offset-cal select routes amplifier offset out
`timescale 1ns/100ps
module sqfd_top #(
	parameter int MS_CYCLES = sqfd_pkg::MS_CYC, // Cycles per millisecond
	parameter int SETTLE_CYCLES = sqfd_pkg::SETTLE_CYC // Leak settle cycles
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic soft_reset_i,
	input wire logic [7:0] channel_firing_i,
	input wire logic [7:0] firing_seq_i,
	input wire logic [7:0] current_target95_i,
	input wire logic [7:0] current_measure_threshold_i,
	input wire logic [7:0] clear_count_i,
	input wire logic [7:0] mos_test_i,
	input wire logic [3:0] fire_enable_pin_i,
	input wire logic [7:0] hold_delay_i,
	input wire logic hold_delay_wr_i,
	input wire logic status_req_i,
	input wire logic leak_start_i,
	input wire logic leak_active_i,
	input wire logic [2:0] leak_chan_i,
	input wire logic leak_high_side_i,
	input wire logic pulldown_select_i,
	input wire logic battery_short_comparator_i,
	input wire logic ground_short_comparator_i,
	input wire logic resist_meas_i,
	input wire logic [2:0] resist_chan_i,
	input wire logic offset_cal_select_i,
	input wire logic spi_cs_n_i,
	input wire logic spi_clk_i,
	output logic [55:0] meas_count_o,
	output logic [3:0] fire_enable_function_o,
	output logic [7:0] driver_allow_o,
	output logic offset_comp_o,
	output logic [7:0] pulldown_en_o,
	output logic [7:0] bias_voltage_source_o,
	output logic bias_high_side_o,
	output logic battery_short_flag_o,
	output logic ground_short_flag_o,
	output logic diag_valid_o,
	output logic aout_oe_o,
	output logic aout_offset_o,
	output logic [7:0] measure_source_current_o,
	output logic [7:0] measure_sink_current_o,
	output logic miso_o,
	output logic miso_oe_o
);
	// Combined reset: pin or soft reset
	logic rst_all;
	assign rst_all = !rst_n_i || soft_reset_i;

	// Three-stage synchronisers for pin and analogue inputs
	logic [7:0] thr_s1, thr_s2, thr_s3, thr_q;
	logic [7:0] t95_s1, t95_s2, t95_s3, t95_q;
	logic [3:0] fen_s1, fen_s2, fen_s3, fen_q;
	logic [2:0] misc_s1, misc_s2, misc_s3, misc_q; // cs_n, stb, stg

	// Sync chains; the level moves only when stages two and three agree
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			thr_s1 <= 8'h00; thr_s2 <= 8'h00; thr_s3 <= 8'h00; thr_q <= 8'h00;
			t95_s1 <= 8'h00; t95_s2 <= 8'h00; t95_s3 <= 8'h00; t95_q <= 8'h00;
			fen_s1 <= 4'h0; fen_s2 <= 4'h0; fen_s3 <= 4'h0; fen_q <= 4'h0;
			misc_s1 <= 3'h1; misc_s2 <= 3'h1; misc_s3 <= 3'h1; misc_q <= 3'h1;
		end else begin
			thr_s1 <= current_measure_threshold_i;
			thr_s2 <= thr_s1;
			thr_s3 <= thr_s2;
			thr_q <= (~(thr_s2 ^ thr_s3) & thr_s3) | ((thr_s2 ^ thr_s3) & thr_q);
			t95_s1 <= current_target95_i;
			t95_s2 <= t95_s1;
			t95_s3 <= t95_s2;
			t95_q <= (~(t95_s2 ^ t95_s3) & t95_s3) | ((t95_s2 ^ t95_s3) & t95_q);
			fen_s1 <= fire_enable_pin_i;
			fen_s2 <= fen_s1;
			fen_s3 <= fen_s2;
			fen_q <= (~(fen_s2 ^ fen_s3) & fen_s3) | ((fen_s2 ^ fen_s3) & fen_q);
			misc_s1 <= {ground_short_comparator_i, battery_short_comparator_i, spi_cs_n_i};
			misc_s2 <= misc_s1;
			misc_s3 <= misc_s2;
			misc_q <= (~(misc_s2 ^ misc_s3) & misc_s3) | ((misc_s2 ^ misc_s3) & misc_q);
		end
	end

	// Select edge detect on the filtered level
	logic cs_prev;
	logic cs_fall;
	assign cs_fall = cs_prev && !misc_q[0];
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) cs_prev <= 1'b1;
		else cs_prev <= misc_q[0];
	end

	// Free-running 25 us step tick
	logic [9:0] step_cnt;
	logic step_tick;
	assign step_tick = (step_cnt == 10'(sqfd_pkg::STEP_CYC - 1));
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) step_cnt <= 10'h000;
		else if (step_tick) step_cnt <= 10'h000;
		else step_cnt <= step_cnt + 10'h001;
	end

	// Offset compensation trigger every 12.8 us
	logic [8:0] comp_cnt;
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			comp_cnt <= 9'h000;
			offset_comp_o <= 1'b0;
		end else begin
			offset_comp_o <= (comp_cnt == 9'(sqfd_pkg::COMP_CYC - 1));
			if (comp_cnt == 9'(sqfd_pkg::COMP_CYC - 1)) comp_cnt <= 9'h000;
			else comp_cnt <= comp_cnt + 9'h001;
		end
	end

	// Per-channel measurement counters
	logic [7:0] started; // Current has passed 95% this firing
	genvar g;
	generate
		for (g = 0; g < sqfd_pkg::NUM_CH; g++) begin : g_ch
			logic [6:0] cnt; // Accumulated time above threshold
			// Start latch for the 95% condition
			always_ff @(posedge mclk_i) begin
				if (rst_all) started[g] <= 1'b0;
				else if (!channel_firing_i[g]) started[g] <= 1'b0;
				else if (t95_q[g]) started[g] <= 1'b1;
			end
			// Counter: reset, clear, saturation restart, accumulate
			always_ff @(posedge mclk_i) begin
				if (rst_all) begin
					cnt <= sqfd_pkg::CNT_ZERO;
				end else if (clear_count_i[g] && !channel_firing_i[g]) begin
					cnt <= sqfd_pkg::CNT_ZERO;
				end else if (firing_seq_i[g] && cnt == sqfd_pkg::CNT_FULL) begin
					cnt <= sqfd_pkg::CNT_ZERO;
				end else if (channel_firing_i[g] && started[g] && thr_q[g] && step_tick
						&& cnt != sqfd_pkg::CNT_FULL) begin
					cnt <= cnt + 7'h01;
				end
			end
			assign meas_count_o[g*7 +: 7] = cnt;
		end
	endgenerate

	// Real-time status sampled every 25 us
	logic [7:0] cur_status;
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) cur_status <= 8'h00;
		else if (step_tick) cur_status <= thr_q;
	end

	// Status request arms the next response
	logic status_pend;
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) status_pend <= 1'b0;
		else if (status_req_i) status_pend <= 1'b1;
		else if (cs_fall) status_pend <= 1'b0;
	end

	// Leakage capture: pending after command, latched on next select fall
	logic leak_pend;
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			leak_pend <= 1'b0;
			battery_short_flag_o <= 1'b0;
			ground_short_flag_o <= 1'b0;
		end else begin
			if (leak_start_i) leak_pend <= 1'b1;
			else if (cs_fall) leak_pend <= 1'b0;
			if (cs_fall && leak_pend) begin
				battery_short_flag_o <= misc_q[1];
				ground_short_flag_o <= misc_q[2];
			end
		end
	end

	// Settle timer after each leakage command
	logic [15:0] settle_cnt;
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			settle_cnt <= 16'h0000;
			diag_valid_o <= 1'b0;
		end else if (leak_start_i) begin
			settle_cnt <= 16'(SETTLE_CYCLES);
			diag_valid_o <= 1'b0;
		end else if (settle_cnt != 16'h0000) begin
			settle_cnt <= settle_cnt - 16'h0001;
		end else begin
			diag_valid_o <= 1'b1;
		end
	end

	// Response snapshot, frozen at the select fall
	logic [15:0] snap;
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) snap <= 16'h0000;
		else if (cs_fall) begin
			snap <= 16'h0000;
			if (status_pend) snap[7:0] <= cur_status;
			snap[sqfd_pkg::RSP_STB] <= leak_pend ? misc_q[1] : battery_short_flag_o;
			snap[sqfd_pkg::RSP_STG] <= leak_pend ? misc_q[2] : ground_short_flag_o;
			snap[sqfd_pkg::RSP_VALID] <= diag_valid_o;
		end
	end

	// Hold delay programming
	logic [7:0] hold_sel;
	always_ff @(posedge mclk_i) begin
		if (rst_all) hold_sel <= 8'h00;
		else if (hold_delay_wr_i) hold_sel <= hold_delay_i;
	end

	// Millisecond tick for hold timers
	logic [15:0] ms_cnt;
	logic ms_tick;
	assign ms_tick = (ms_cnt == 16'(MS_CYCLES - 1));
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) ms_cnt <= 16'h0000;
		else if (ms_tick) ms_cnt <= 16'h0000;
		else ms_cnt <= ms_cnt + 16'h0001;
	end

	// Per-pin filter, hold timer and enable function
	logic [3:0] fen_filt;
	generate
		for (g = 0; g < sqfd_pkg::NUM_FEN; g++) begin : g_fen
			logic [8:0] filt_cnt; // High-time counter
			logic [9:0] hold_ms; // Remaining hold in ms
			logic [9:0] hold_len; // Programmed hold in ms
			logic pin_prev; // Previous synced level
			always_comb begin
				case (hold_sel[g*2 +: 2])
					sqfd_pkg::HOLD_128: hold_len = sqfd_pkg::HOLD_MS_128;
					sqfd_pkg::HOLD_256: hold_len = sqfd_pkg::HOLD_MS_256;
					sqfd_pkg::HOLD_512: hold_len = sqfd_pkg::HOLD_MS_512;
					default: hold_len = 10'h000; // HOLD_0
				endcase
			end
			// Filter restarts on low, asserts after the filter time
			always_ff @(posedge mclk_i) begin
				if (rst_all || !fen_q[g]) begin
					filt_cnt <= 9'h000;
					fen_filt[g] <= 1'b0;
				end else if (filt_cnt == 9'(sqfd_pkg::FILT_CYC)) begin
					fen_filt[g] <= 1'b1;
				end else begin
					filt_cnt <= filt_cnt + 9'h001;
				end
			end
			// Hold timer: reload on rise, run down while low
			always_ff @(posedge mclk_i) begin
				if (rst_all) begin
					pin_prev <= 1'b0;
					hold_ms <= 10'h000;
				end else begin
					pin_prev <= fen_q[g];
					if (fen_q[g] && !pin_prev) hold_ms <= hold_len;
					else if (!fen_q[g] && ms_tick && hold_ms != 10'h000)
						hold_ms <= hold_ms - 10'h001;
				end
			end
			// Enable is pin OR latch; latch needs a prior valid high
			logic latch_on;
			always_ff @(posedge mclk_i) begin
				if (rst_all) latch_on <= 1'b0;
				else if (fen_filt[g]) latch_on <= 1'b1;
				else if (hold_ms == 10'h000) latch_on <= 1'b0;
			end
			always_ff @(posedge mclk_i) begin
				if (rst_all) fire_enable_function_o[g] <= 1'b0;
				else fire_enable_function_o[g] <= fen_filt[g] || latch_on;
			end
		end
	endgenerate

	// Drivers allowed by their pair's enable or the MOS test
	always_ff @(posedge mclk_i) begin
		if (rst_all) driver_allow_o <= 8'h00;
		else for (int i = 0; i < 8; i++)
			driver_allow_o[i] <= fire_enable_function_o[i/2] || mos_test_i[i];
	end

	// Pulldown and bias selection for leakage tests
	always_ff @(posedge mclk_i) begin
		if (rst_all) begin
			pulldown_en_o <= 8'hFF;
			bias_voltage_source_o <= 8'h00;
			bias_high_side_o <= 1'b0;
		end else if (leak_active_i) begin
			bias_voltage_source_o <= 8'h01 << leak_chan_i;
			bias_high_side_o <= leak_high_side_i;
			if (pulldown_select_i) pulldown_en_o <= ~(8'h01 << leak_chan_i);
			else pulldown_en_o <= 8'h00;
		end else begin
			pulldown_en_o <= 8'hFF;
			bias_voltage_source_o <= 8'h00;
			bias_high_side_o <= 1'b0;
		end
	end

	// Resistance measurement currents and analogue output
	always_ff @(posedge mclk_i) begin
		if (rst_all || !resist_meas_i) begin
			aout_oe_o <= 1'b0;
			aout_offset_o <= 1'b0;
			measure_source_current_o <= 8'h00;
			measure_sink_current_o <= 8'h00;
		end else begin
			aout_oe_o <= 1'b1;
			aout_offset_o <= offset_cal_select_i;
			measure_source_current_o <= 8'h01 << resist_chan_i;
			measure_sink_current_o <= 8'h01 << resist_chan_i;
		end
	end

	// Link side: shift the frozen snapshot out MSB first on falling edges.
	// The select pin clears the frame state, since the link clock stops.
	logic [3:0] bit_idx;
	always_ff @(negedge spi_clk_i or posedge spi_cs_n_i) begin
		if (spi_cs_n_i) begin
			bit_idx <= 4'hF;
			miso_o <= 1'b0;
			miso_oe_o <= 1'b0;
		end else begin
			miso_oe_o <= 1'b1;
			miso_o <= snap[bit_idx];
			bit_idx <= bit_idx - 4'h1;
		end
	end
endmodule

// ---- dv/sqfd_checker.sv ----
/* Checker for the squib measure, enable and diagnostic block.
   Bound to sqfd_top and sees its ports only. */
`timescale 1ns/100ps
module sqfd_checker (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic soft_reset_i,
	input wire logic [7:0] channel_firing_i,
	input wire logic [7:0] firing_seq_i,
	input wire logic [7:0] clear_count_i,
	input wire logic [3:0] fire_enable_pin_i,
	input wire logic leak_active_i,
	input wire logic [2:0] leak_chan_i,
	input wire logic pulldown_select_i,
	input wire logic resist_meas_i,
	input wire logic [55:0] meas_count_o,
	input wire logic [3:0] fire_enable_function_o,
	input wire logic offset_comp_o,
	input wire logic [7:0] pulldown_en_o,
	input wire logic aout_oe_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	logic [8:0] gap; // Cycles since last compensation pulse
	logic seen; // A first pulse has passed
	// Pulse spacing counter
	always_ff @(posedge mclk_i) begin
		seen <= rst_n_i && (seen || offset_comp_o);
		gap <= (!rst_n_i || offset_comp_o) ? 9'h000 : gap + 9'h001;
	end
	property p_clr;
		clear_count_i[1] && !channel_firing_i[1] |=> meas_count_o[13:7] == 7'h00;
	endproperty
	a_clr: assert property (p_clr) else $error("count not cleared");
	property p_clrf;
		clear_count_i[1] && channel_firing_i[1] && !soft_reset_i && !firing_seq_i[1]
			|=> meas_count_o[13:7] >= $past(meas_count_o[13:7]);
	endproperty
	a_clrf: assert property (p_clrf) else $error("count cleared while firing");
	property p_sat;
		meas_count_o[13:7] == 7'h7F && firing_seq_i[1] |=> meas_count_o[13:7] == 7'h00;
	endproperty
	a_sat: assert property (p_sat) else $error("full count kept on new sequence");
	property p_stop;
		meas_count_o[13:7] == 7'h7F && !firing_seq_i[1] && !clear_count_i[1] && !soft_reset_i
			|=> meas_count_o[13:7] == 7'h7F;
	endproperty
	a_stop: assert property (p_stop) else $error("full count moved");
	property p_comp;
		offset_comp_o && seen |-> gap == 9'h13F;
	endproperty
	a_comp: assert property (p_comp) else $error("compensation spacing wrong");
	property p_filt;
		$rose(fire_enable_function_o[0]) |-> $past(fire_enable_pin_i[0], 300);
	endproperty
	a_filt: assert property (p_filt) else $error("enable before filter time");
	property p_pd;
		(leak_active_i && !pulldown_select_i && !soft_reset_i) [*2] |-> pulldown_en_o == 8'h00;
	endproperty
	a_pd: assert property (p_pd) else $error("pulldown left on in leak test");
	property p_loop;
		(leak_active_i && pulldown_select_i && leak_chan_i == 3'h3 && !soft_reset_i) [*2]
			|-> pulldown_en_o == 8'hF7;
	endproperty
	a_loop: assert property (p_loop) else $error("loop test pulldowns wrong");
	property p_aout;
		(!resist_meas_i) [*2] |-> !aout_oe_o;
	endproperty
	a_aout: assert property (p_aout) else $error("analogue out driven idle");
	// Main scenarios reached
	c_cnt: cover property (meas_count_o[13:7] == 7'h02);
	c_fen: cover property ($rose(fire_enable_function_o[0]));
	c_loop: cover property (pulldown_en_o == 8'hF7);
endmodule
bind sqfd_top sqfd_checker i_chk (.*);

// ---- dv/sqfd_host.sv ----
/* Host model: SPI master that reads one 16-bit response frame.
   Link clock idles high and runs only inside a frame. */
`timescale 1ns/100ps
module sqfd_host (
	output logic spi_cs_n_o,
	output logic spi_clk_o,
	input wire logic miso_i,
	input wire logic miso_oe_i
);
	// Idle: deselected, clock still
	initial begin
		spi_cs_n_o = 1'b1;
		spi_clk_o = 1'b1;
	end
	// One frame, MSB first, 64 ns link period
	task automatic frame(output logic [15:0] word);
		#7; // Start off the core clock edge
		spi_cs_n_o = 1'b0;
		#400;
		for (int i = 15; i >= 0; i--) begin
			spi_clk_o = 1'b0;
			#32;
			spi_clk_o = 1'b1;
			word[i] = miso_oe_i ? miso_i : 1'bx;
			#32;
		end
		#40;
		spi_cs_n_o = 1'b1;
		#200;
	endtask
endmodule

// ---- dv/sqfd_tb.sv ----
/* Self-checking bench for the squib measure and enable block.
   Host model makes the link clock; checker is bound to the top. */
`timescale 1ns/100ps
module testbench;
	logic mclk_i, rst_n_i, soft_reset_i, hold_delay_wr_i, status_req_i, leak_start_i;
	logic leak_active_i, leak_high_side_i, pulldown_select_i, resist_meas_i;
	logic battery_short_comparator_i, ground_short_comparator_i, offset_cal_select_i;
	logic [7:0] channel_firing_i, firing_seq_i, current_target95_i;
	logic [7:0] current_measure_threshold_i, clear_count_i, mos_test_i, hold_delay_i;
	logic [3:0] fire_enable_pin_i, fire_enable_function_o;
	logic [2:0] leak_chan_i, resist_chan_i;
	logic spi_cs_n_i, spi_clk_i, miso_o, miso_oe_o, offset_comp_o, bias_high_side_o;
	logic battery_short_flag_o, ground_short_flag_o, diag_valid_o, aout_oe_o, aout_offset_o;
	logic [55:0] meas_count_o;
	logic [7:0] driver_allow_o, pulldown_en_o, bias_voltage_source_o;
	logic [7:0] measure_source_current_o, measure_sink_current_o;
	int miscompares, check_count, cycles;
	logic [15:0] word; // Last response frame
	sqfd_top #(.MS_CYCLES(10), .SETTLE_CYCLES(20)) i_dut (.*);
	sqfd_host i_host (.spi_cs_n_o(spi_cs_n_i), .spi_clk_o(spi_clk_i), .miso_i(miso_o),
		.miso_oe_i(miso_oe_o));
	// Core clock 25 MHz
	initial begin
		mclk_i = 1'b0;
		forever #20 mclk_i = ~mclk_i;
	end
	// Hang guard
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 90000) begin
			miscompares++;
			end_sim();
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk_i);
	endtask
	task automatic chk(input string name, input logic [55:0] exp, input logic [55:0] got);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Wait for channel 1 count to reach one
	task automatic wait_one;
		int n;
		n = 0;
		while (meas_count_o[13:7] !== 7'h01 && n < 800) begin
			cyc(1);
			n++;
		end
	endtask
	task automatic end_sim;
		$display("Checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic t_reset;
		chk("count", 56'h0, meas_count_o);
		chk("pulldown", 56'hFF, pulldown_en_o);
		chk("miso_oe", 56'h0, miso_oe_o);
		$display("t_reset done");
	endtask
	// Counting, clear rules, status frame
	task automatic t_count;
		channel_firing_i <= 8'h02;
		current_measure_threshold_i <= 8'h02;
		cyc(700);
		chk("no95", 56'h0, meas_count_o);
		current_target95_i <= 8'h02;
		wait_one();
		cyc(630);
		chk("step", 7'h02, meas_count_o[13:7]);
		clear_count_i <= 8'h02;
		firing_seq_i <= 8'h02;
		cyc(1);
		clear_count_i <= 8'h00;
		firing_seq_i <= 8'h00;
		cyc(2);
		chk("clr_firing", 7'h02, meas_count_o[13:7]);
		status_req_i <= 1'b1;
		cyc(1);
		status_req_i <= 1'b0;
		cyc(1);
		i_host.frame(word);
		cyc(1);
		chk("status", 8'h02, word[7:0]);
		channel_firing_i <= 8'h00;
		soft_reset_i <= 1'b1;
		cyc(1);
		soft_reset_i <= 1'b0;
		cyc(2);
		chk("soft", 7'h00, meas_count_o[13:7]);
		channel_firing_i <= 8'h02;
		wait_one();
		chk("refire", 7'h01, meas_count_o[13:7]);
		channel_firing_i <= 8'h00;
		cyc(2);
		clear_count_i <= 8'h02;
		cyc(1);
		clear_count_i <= 8'h00;
		cyc(1);
		chk("clear", 7'h00, meas_count_o[13:7]);
		$display("t_count done");
	endtask
	// Saturation stop, restart on a new sequence, neighbour kept
	task automatic t_sat;
		channel_firing_i <= 8'h03;
		current_target95_i <= 8'h03;
		wait_one();
		cyc(77600);
		current_measure_threshold_i <= 8'h03;
		cyc(1200);
		current_measure_threshold_i <= 8'h02;
		cyc(700);
		chk("full", 7'h7F, meas_count_o[13:7]);
		chk("ch0_two", 7'h02, meas_count_o[6:0]);
		firing_seq_i <= 8'h03;
		cyc(1);
		firing_seq_i <= 8'h00;
		cyc(1);
		chk("restart", 7'h00, meas_count_o[13:7]);
		chk("kept", 7'h02, meas_count_o[6:0]);
		channel_firing_i <= 8'h00;
		$display("t_sat done");
	endtask
	// Filter, hold timer, enable mapping
	task automatic t_fen;
		hold_delay_i <= 8'h01;
		hold_delay_wr_i <= 1'b1;
		cyc(1);
		hold_delay_wr_i <= 1'b0;
		fire_enable_pin_i <= 4'h3;
		cyc(300);
		chk("filter_low", 4'h0, fire_enable_function_o);
		cyc(100);
		chk("filter_high", 4'h3, fire_enable_function_o);
		chk("allow", 8'h0F, driver_allow_o);
		fire_enable_pin_i <= 4'h0;
		cyc(20);
		chk("hold", 4'h1, fire_enable_function_o);
		mos_test_i <= 8'h80;
		cyc(3);
		chk("mos", 8'h83, driver_allow_o);
		mos_test_i <= 8'h00;
		cyc(1230);
		chk("hold_run", 4'h1, fire_enable_function_o);
		cyc(100);
		chk("hold_end", 4'h0, fire_enable_function_o);
		$display("t_fen done");
	endtask
	// Leak, loop and resistance selects
	task automatic t_diag;
		leak_chan_i <= 3'h3;
		leak_high_side_i <= 1'b1;
		leak_active_i <= 1'b1;
		battery_short_comparator_i <= 1'b1;
		leak_start_i <= 1'b1;
		cyc(1);
		leak_start_i <= 1'b0;
		cyc(2);
		chk("settling", 1'b0, diag_valid_o);
		cyc(28);
		chk("pd_off", 8'h00, pulldown_en_o);
		chk("bias", 9'h108, {bias_high_side_o, bias_voltage_source_o});
		i_host.frame(word);
		cyc(1);
		chk("leak_flags", 3'h5, word[10:8]);
		chk("flag_out", 2'h2, {battery_short_flag_o, ground_short_flag_o});
		pulldown_select_i <= 1'b1;
		cyc(3);
		chk("pd_loop", 8'hF7, pulldown_en_o);
		leak_active_i <= 1'b0;
		resist_chan_i <= 3'h2;
		resist_meas_i <= 1'b1;
		cyc(3);
		chk("src_sink", 16'h0404, {measure_source_current_o, measure_sink_current_o});
		chk("aout", 2'h2, {aout_oe_o, aout_offset_o});
		offset_cal_select_i <= 1'b1;
		cyc(3);
		chk("cal", 2'h3, {aout_oe_o, aout_offset_o});
		resist_meas_i <= 1'b0;
		cyc(3);
		chk("aout_off", 1'b0, aout_oe_o);
		$display("t_diag done");
	endtask
	// Main sequence
	initial begin
		{rst_n_i, soft_reset_i, hold_delay_wr_i, status_req_i, leak_start_i} = '0;
		{leak_active_i, leak_high_side_i, pulldown_select_i, resist_meas_i} = '0;
		{battery_short_comparator_i, ground_short_comparator_i, offset_cal_select_i} = '0;
		{channel_firing_i, firing_seq_i, current_target95_i} = '0;
		{current_measure_threshold_i, clear_count_i, mos_test_i, hold_delay_i} = '0;
		{fire_enable_pin_i, leak_chan_i, resist_chan_i} = '0;
		cyc(5);
		rst_n_i <= 1'b1;
		cyc(6);
		t_reset();
		t_count();
		t_sat();
		t_fen();
		t_diag();
		end_sim();
	end
endmodule
